// ---- rtl/tcc_pkg.sv ----
// package for the sixteen-bit timer counter core: register map, fields, carriers
package tcc_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [9:0] IDX_RUN_CONTROL    = 10'h180;
  localparam logic [9:0] IDX_STATUS         = 10'h181;
  localparam logic [9:0] IDX_MODE_SELECT    = 10'h182;
  localparam logic [9:0] IDX_FLIPFLOP_CTRL  = 10'h183;
  localparam logic [9:0] IDX_COMPARE_A_LOW  = 10'h188;
  localparam logic [9:0] IDX_COMPARE_A_HIGH = 10'h189;
  localparam logic [9:0] IDX_COMPARE_B_LOW  = 10'h18a;
  localparam logic [9:0] IDX_COMPARE_B_HIGH = 10'h18b;
  localparam logic [9:0] IDX_CAPTURE_A_LOW  = 10'h18c;
  localparam logic [9:0] IDX_CAPTURE_A_HIGH = 10'h18d;
  localparam logic [9:0] IDX_CAPTURE_B_LOW  = 10'h18e;
  localparam logic [9:0] IDX_CAPTURE_B_HIGH = 10'h18f;

  // run_control fields
  localparam int unsigned BIT_COUNTER_RUN   = 0;
  localparam int unsigned BIT_PRESCALER_RUN = 2;
  localparam int unsigned BIT_DOUBLE_BUF_EN = 7;
  // mode_select fields
  localparam int unsigned LSB_CLOCK_SELECT  = 0;
  localparam int unsigned BIT_MATCH_CLR_EN  = 2;
  localparam int unsigned BIT_SOFT_CAPTURE  = 5;

  // reset values
  localparam logic [7:0] RST_RUN_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE_SELECT = 8'h20;
  localparam logic [7:0] RST_FLIPFLOP    = 8'h00;
  localparam logic [15:0] RST_WORD       = 16'h0000;

  // timing constants
  localparam logic [1:0]  BASE_DIV_LAST  = 2'h3;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] COUNT_ONE      = 16'h0001;
  localparam logic [4:0]  PRESC_ONE      = 5'h01;
  localparam logic [4:0]  PRESC_DIV8_END = 5'h07;
  localparam logic [4:0]  PRESC_DIV32_END = 5'h1f;

  // count clock select encoding
  localparam logic [1:0] CLK_SEL_EXTERNAL = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV2     = 2'h1;
  localparam logic [1:0] CLK_SEL_DIV8     = 2'h2;
  localparam logic [1:0] CLK_SEL_DIV32    = 2'h3;

  typedef struct packed {
    logic div2;
    logic div8;
    logic div32;
  } tcc_tick_type;

  typedef struct packed {
    logic counter_overflow_irq;
    logic match_a;
    logic match_b;
  } tcc_event_type;
endpackage : tcc_pkg

// ---- rtl/tcc_core.sv ----
// sixteen-bit timer counter channel with prescaler, compares, captures, wishbone slave
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
module tcc_core #(
  parameter int unsigned ADR_W = 12
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone classic slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // prescaler source tick from the clock gear, same clock domain
  input  wire logic                 src_tick_i,
  // pins
  input  wire logic                 external_clock_input_i,
  input  wire logic                 external_trigger_input_i,
  // channel outputs
  output tcc_pkg::tcc_event_type    events_o,
  output logic      [15:0]          up_counter_o
);
  import tcc_pkg::*;

  logic [7:0]    run_control_r;
  logic [7:0]    mode_select_r;
  logic [7:0]    flipflop_control_r;
  logic [1:0]    src_div_r;
  logic [4:0]    presc_r;
  logic [15:0]   up_counter_r;
  logic [15:0]   compare_a_r;
  logic [15:0]   compare_b_r;
  logic [15:0]   buffer_a_r;
  logic          buf_low_flag_r;
  logic          buf_high_flag_r;
  logic          cmp_a_valid_r;
  logic          cmp_b_valid_r;
  logic [15:0]   capture_a_r;
  logic [15:0]   capture_b_r;
  logic [2:0]    ext_clk_sync_r;
  logic [2:0]    ext_trg_sync_r;
  logic          ack_r;
  logic [31:0]   dat_r;
  tcc_event_type events_r;

  logic          base_tick;
  tcc_tick_type  tick;
  logic          count_tick;
  logic          counter_run;
  logic          prescaler_run;
  logic          double_buffer_enable;
  logic          match_clear_enable;
  logic          hit_a;
  logic          hit_b;
  logic          clear_hit;
  logic          transfer;
  logic          wb_req;
  logic          wr_en;
  logic [9:0]    idx;
  logic [7:0]    wr_byte;
  logic [15:0]   up_counter_nxt;

  assign counter_run          = run_control_r[BIT_COUNTER_RUN];
  assign prescaler_run        = run_control_r[BIT_PRESCALER_RUN];
  assign double_buffer_enable = run_control_r[BIT_DOUBLE_BUF_EN];
  assign match_clear_enable   = mode_select_r[BIT_MATCH_CLR_EN];

  // bus decode: one request per access, taken in the cycle before ack
  assign wb_req  = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_en   = wb_req && wb_we_i && wb_sel_i[0];
  assign idx     = wb_adr_i[11:2];
  assign wr_byte = wb_dat_i[7:0];

  // base tick: source tick divided by four
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_div_r <= 2'h0;
    end else if (src_tick_i) begin
      src_div_r <= src_div_r + 2'h1;
    end
  end
  assign base_tick = src_tick_i && (src_div_r == BASE_DIV_LAST);

  // prescaler
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_r <= 5'h00;
    end else if (!prescaler_run) begin
      presc_r <= 5'h00;
    end else if (base_tick) begin
      presc_r <= presc_r + PRESC_ONE;
    end
  end

  // each tick fires as the matching prescaler bits roll over
  assign tick.div2  = prescaler_run && base_tick && presc_r[0];
  assign tick.div8  = prescaler_run && base_tick && (presc_r[2:0] == PRESC_DIV8_END[2:0]);
  assign tick.div32 = prescaler_run && base_tick && (presc_r == PRESC_DIV32_END);

  // external pins pass two flops; third stage only feeds the edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_clk_sync_r <= 3'h0;
      ext_trg_sync_r <= 3'h0;
    end else begin
      ext_clk_sync_r <= {ext_clk_sync_r[1:0], external_clock_input_i};
      ext_trg_sync_r <= {ext_trg_sync_r[1:0], external_trigger_input_i};
    end
  end

  // count clock select
  always_comb begin
    case (mode_select_r[LSB_CLOCK_SELECT +: 2])
      CLK_SEL_EXTERNAL: count_tick = ext_clk_sync_r[1] && !ext_clk_sync_r[2];
      CLK_SEL_DIV2:     count_tick = tick.div2;
      CLK_SEL_DIV8:     count_tick = tick.div8;
      CLK_SEL_DIV32:    count_tick = tick.div32;
      default:          count_tick = 1'b0;
    endcase
  end

  // comparators; a compare with only its low byte written stays quiet
  assign hit_a     = counter_run && count_tick && cmp_a_valid_r
                     && (up_counter_r == compare_a_r);
  assign hit_b     = counter_run && count_tick && cmp_b_valid_r
                     && (up_counter_r == compare_b_r);
  assign clear_hit = hit_b && match_clear_enable;
  assign transfer  = hit_b && double_buffer_enable
                     && buf_low_flag_r && buf_high_flag_r;

  // up counter
  always_comb begin
    up_counter_nxt = up_counter_r;
    if (!counter_run) begin
      up_counter_nxt = RST_WORD;
    end else if (clear_hit) begin
      up_counter_nxt = RST_WORD;
    end else if (count_tick) begin
      up_counter_nxt = up_counter_r + COUNT_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_counter_r <= RST_WORD;
    end else begin
      up_counter_r <= up_counter_nxt;
    end
  end
  assign up_counter_o = up_counter_r;

  // event pulses, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      events_r <= '0;
    end else begin
      events_r.counter_overflow_irq <= counter_run && count_tick && !clear_hit
                                       && (up_counter_r == COUNT_ALL_ONES);
      events_r.match_a <= hit_a;
      events_r.match_b <= hit_b;
    end
  end
  assign events_o = events_r;

  // control registers (eleven documented bytes plus status)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_control_r      <= RST_RUN_CONTROL;
      mode_select_r      <= RST_MODE_SELECT;
      flipflop_control_r <= RST_FLIPFLOP;
    end else if (wr_en) begin
      case (idx)
        IDX_RUN_CONTROL:   run_control_r      <= wr_byte;
        IDX_MODE_SELECT:   mode_select_r      <= wr_byte;
        IDX_FLIPFLOP_CTRL: flipflop_control_r <= wr_byte;
        default:           run_control_r      <= run_control_r;
      endcase
    end
  end

  // compare a and its buffer share one address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_a_r <= RST_WORD;
      buffer_a_r  <= RST_WORD;
    end else begin
      if (wr_en && idx == IDX_COMPARE_A_LOW) begin
        buffer_a_r[7:0] <= wr_byte;
      end
      if (wr_en && idx == IDX_COMPARE_A_HIGH) begin
        buffer_a_r[15:8] <= wr_byte;
      end
      if (transfer) begin
        compare_a_r <= buffer_a_r;
      end else if (wr_en && !double_buffer_enable && idx == IDX_COMPARE_A_LOW) begin
        compare_a_r[7:0] <= wr_byte;
      end else if (wr_en && !double_buffer_enable && idx == IDX_COMPARE_A_HIGH) begin
        compare_a_r[15:8] <= wr_byte;
      end
    end
  end

  // buffer written flags: a write in the transfer cycle keeps its flag set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_low_flag_r  <= 1'b0;
      buf_high_flag_r <= 1'b0;
    end else begin
      buf_low_flag_r  <= (wr_en && idx == IDX_COMPARE_A_LOW)
                         || (buf_low_flag_r && !transfer);
      buf_high_flag_r <= (wr_en && idx == IDX_COMPARE_A_HIGH)
                         || (buf_high_flag_r && !transfer);
    end
  end

  // compare b, and valid flags: low write disarms (compare a only with double buffering off), high write arms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_b_r   <= RST_WORD;
      cmp_a_valid_r <= 1'b0;
      cmp_b_valid_r <= 1'b0;
    end else if (wr_en) begin
      case (idx)
        IDX_COMPARE_A_LOW:  cmp_a_valid_r <= double_buffer_enable && cmp_a_valid_r;
        IDX_COMPARE_A_HIGH: cmp_a_valid_r <= 1'b1;
        IDX_COMPARE_B_LOW: begin
          compare_b_r[7:0] <= wr_byte;
          cmp_b_valid_r    <= 1'b0;
        end
        IDX_COMPARE_B_HIGH: begin
          compare_b_r[15:8] <= wr_byte;
          cmp_b_valid_r     <= 1'b1;
        end
        default: cmp_b_valid_r <= cmp_b_valid_r;
      endcase
    end
  end

  // captures: a by software write with soft capture bit low, b on trigger pin rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_a_r <= RST_WORD;
      capture_b_r <= RST_WORD;
    end else begin
      if (wr_en && idx == IDX_MODE_SELECT && !wr_byte[BIT_SOFT_CAPTURE]) begin
        capture_a_r <= up_counter_r;
      end
      if (ext_trg_sync_r[1] && !ext_trg_sync_r[2]) begin
        capture_b_r <= up_counter_r;
      end
    end
  end

  // bus answer: ack one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      dat_r <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (idx)
          IDX_RUN_CONTROL:    dat_r[7:0] <= run_control_r;
          IDX_STATUS:         dat_r[3:0] <= {buf_high_flag_r, buf_low_flag_r,
                                             cmp_b_valid_r, cmp_a_valid_r};
          IDX_MODE_SELECT:    dat_r[7:0] <= mode_select_r;
          IDX_FLIPFLOP_CTRL:  dat_r[7:0] <= flipflop_control_r;
          IDX_CAPTURE_A_LOW:  dat_r[7:0] <= capture_a_r[7:0];
          IDX_CAPTURE_A_HIGH: dat_r[7:0] <= capture_a_r[15:8];
          IDX_CAPTURE_B_LOW:  dat_r[7:0] <= capture_b_r[7:0];
          IDX_CAPTURE_B_HIGH: dat_r[7:0] <= capture_b_r[15:8];
          default:            dat_r      <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // checks
  sequence seq_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence seq_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence seq_full_buffer_hit;
    hit_b && double_buffer_enable && buf_low_flag_r && buf_high_flag_r;
  endsequence

  bus_ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_wb_req |=> seq_ack_pulse) else $error("ack not a single pulse after request");

  presc_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !prescaler_run |=> presc_r == 5'h00) else $error("prescaler not held at zero");

  tick_nest_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick.div32 |-> tick.div8 && tick.div2 && presc_r == PRESC_DIV32_END)
    else $error("slow tick without faster ticks");

  counter_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !counter_run |=> up_counter_r == RST_WORD) else $error("stopped counter not zero");

  count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    counter_run && count_tick && !clear_hit && up_counter_r != COUNT_ALL_ONES
    |=> up_counter_r == $past(up_counter_r) + COUNT_ONE)
    else $error("counter did not step by one");

  wrap_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    counter_run && count_tick && !clear_hit && up_counter_r == COUNT_ALL_ONES
    |=> up_counter_r == RST_WORD && events_o.counter_overflow_irq ##1
        !events_o.counter_overflow_irq) else $error("wrap without single overflow");

  match_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_hit |=> up_counter_r == RST_WORD && events_o.match_b)
    else $error("match clear failed");

  low_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && idx == IDX_COMPARE_B_LOW |=> !cmp_b_valid_r ##0 !hit_b)
    else $error("compare active after low byte only");

  buffer_move_a: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_full_buffer_hit ##0 !wr_en |=> compare_a_r == $past(buffer_a_r)
    && !buf_low_flag_r && !buf_high_flag_r) else $error("buffer transfer wrong");

  shared_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && idx == IDX_COMPARE_A_HIGH && double_buffer_enable && !transfer
    |=> compare_a_r == $past(compare_a_r)) else $error("compare a written through buffer");

  // a half-written buffer must never reach compare a, or a stale byte pair leaks out
  transfer_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hit_b && double_buffer_enable && !(buf_low_flag_r && buf_high_flag_r)
    |=> $stable(compare_a_r)) else $error("transfer with a buffer byte missing");

  overflow_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    events_o.counter_overflow_irq |-> up_counter_o == RST_WORD)
    else $error("overflow pulse with counter not at zero");

  count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    counter_run && !count_tick |=> $stable(up_counter_r))
    else $error("counter moved without a tick");

  capture_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_trg_sync_r[1] && !ext_trg_sync_r[2] |=> capture_b_r == $past(up_counter_r))
    else $error("pin capture missed the counter value");
endmodule : tcc_core

// ---- tb/tcc_core_test.sv ----
// self-checking bench for the sixteen-bit timer counter core
`timescale 1ns/100ps
module sixteen_bit_timer_counter_core_test;
  import tcc_pkg::*;

  typedef struct packed {
    logic       we;
    logic [9:0] idx;
    logic [7:0] dat;
  } tcc_row_type;

  // reads carry the expected byte in dat
  localparam tcc_row_type ROWS [17] = '{
    '{1'b0, IDX_RUN_CONTROL, RST_RUN_CONTROL},
    '{1'b0, IDX_MODE_SELECT, RST_MODE_SELECT},
    '{1'b0, IDX_FLIPFLOP_CTRL, RST_FLIPFLOP},
    '{1'b0, IDX_STATUS, 8'h00},
    '{1'b0, IDX_COMPARE_A_LOW, 8'h00},
    '{1'b0, IDX_CAPTURE_B_HIGH, 8'h00},
    '{1'b0, 10'h184, 8'h00},
    '{1'b1, IDX_FLIPFLOP_CTRL, 8'h5a},
    '{1'b0, IDX_FLIPFLOP_CTRL, 8'h5a},
    '{1'b1, 10'h184, 8'hff},
    '{1'b0, 10'h184, 8'h00},
    '{1'b1, IDX_COMPARE_B_LOW, 8'h07},
    '{1'b0, IDX_STATUS, 8'h00},
    '{1'b1, IDX_COMPARE_B_HIGH, 8'h00},
    '{1'b0, IDX_STATUS, 8'h02},
    '{1'b1, IDX_COMPARE_A_LOW, 8'h02},
    '{1'b1, IDX_COMPARE_A_HIGH, 8'h00}
  };

  logic          clk_i;
  logic          rst_i;
  logic          wb_cyc;
  logic          wb_stb;
  logic          wb_we;
  logic [11:0]   wb_adr;
  logic [3:0]    wb_sel;
  logic [31:0]   wb_dat_w;
  logic [31:0]   wb_dat_r;
  logic          wb_ack;
  logic          src_tick;
  logic          ext_clk;
  logic          ext_trig;
  tcc_event_type events;
  logic [15:0]   counter;
  logic [15:0]   irq_val;
  int            irq_seen;
  int            num_errors;
  int            n_tests;

  tcc_core DUT (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .wb_cyc_i                 (wb_cyc),
    .wb_stb_i                 (wb_stb),
    .wb_we_i                  (wb_we),
    .wb_adr_i                 (wb_adr),
    .wb_sel_i                 (wb_sel),
    .wb_dat_i                 (wb_dat_w),
    .wb_dat_o                 (wb_dat_r),
    .wb_ack_o                 (wb_ack),
    .src_tick_i               (src_tick),
    .external_clock_input_i   (ext_clk),
    .external_trigger_input_i (ext_trig),
    .events_o                 (events),
    .up_counter_o             (counter)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // overflow pulses are counted all run long; only the wrap test expects any
  always @(posedge clk_i) begin
    if (events.counter_overflow_irq === 1'b1) begin
      irq_seen <= irq_seen + 1;
      irq_val  <= counter;
    end
  end

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one classic cycle; ack and read data are taken at the same edge
  task automatic wb_xfer(input logic we, input logic [9:0] idx, input logic [7:0] d,
                         output logic [7:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= {idx, 2'b00};
    wb_dat_w <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    check("bus ack", 16'h0001, {15'h0000, wb_ack});
    q = wb_dat_r[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb_xfer(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [9:0] idx, output logic [7:0] q);
    wb_xfer(1'b0, idx, 8'h00, q);
  endtask : rd

  // edges between two counter changes, skipping the first partial span
  task automatic measure(output int p);
    logic [15:0] v;
    int n;
    v = counter;
    n = 0;
    while (counter === v && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    v = counter;
    p = 0;
    while (counter === v && p < 400) begin
      @(posedge clk_i);
      p++;
    end
  endtask : measure

  task automatic wait_ev(input logic on_a, output logic [15:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((on_a ? events.match_a : events.match_b) !== 1'b1 && n < 2000);
    v = counter;
  endtask : wait_ev

  initial begin : main
    logic [7:0]  q;
    logic [7:0]  q2;
    logic [15:0] v;
    int          p;
    num_errors = 0;
    n_tests    = 0;
    irq_seen   = 0;
    irq_val    = 16'h0000;
    rst_i      = 1'b1;
    wb_cyc     = 1'b0;
    wb_stb     = 1'b0;
    wb_we      = 1'b0;
    wb_adr     = 12'h000;
    wb_sel     = 4'h1;
    wb_dat_w   = 32'h00000000;
    src_tick   = 1'b1;
    ext_clk    = 1'b0;
    ext_trig   = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      wb_xfer(ROWS[i].we, ROWS[i].idx, ROWS[i].dat, q);
      if (!ROWS[i].we) check("register read", {8'h00, ROWS[i].dat}, {8'h00, q});
    end
    // div2, div8, div32 against a steady source tick
    wr(IDX_RUN_CONTROL, 8'h05);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_MODE_SELECT, 8'(33 + i));
      measure(p);
      check("tick period", 16'(8 << (2 * i)), 16'(p));
    end
    // halted prescaler freezes the count, so captures have a known value
    wr(IDX_RUN_CONTROL, 8'h01);
    repeat (4) @(posedge clk_i);
    v = counter;
    repeat (300) @(posedge clk_i);
    check("halted count", v, counter);
    ext_trig <= 1'b1;
    repeat (4) @(posedge clk_i);
    ext_trig <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(IDX_CAPTURE_B_LOW, q);
    rd(IDX_CAPTURE_B_HIGH, q2);
    check("capture b", v, {q2, q});
    wr(IDX_MODE_SELECT, 8'h03);
    rd(IDX_CAPTURE_A_LOW, q);
    rd(IDX_CAPTURE_A_HIGH, q2);
    check("capture a", v, {q2, q});
    wr(IDX_RUN_CONTROL, 8'h04);
    repeat (2) @(posedge clk_i);
    check("stopped count", 16'h0000, counter);
    // external pin counting
    wr(IDX_MODE_SELECT, 8'h20);
    wr(IDX_RUN_CONTROL, 8'h05);
    repeat (5) begin
      ext_clk <= 1'b1;
      repeat (2) @(posedge clk_i);
      ext_clk <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
    check("external count", 16'h0005, counter);
    // compare a holds 2, buffer gets 5, compare b 7 clears the counter
    wr(IDX_RUN_CONTROL, 8'h80);
    wr(IDX_COMPARE_A_LOW, 8'h05);
    wr(IDX_COMPARE_A_HIGH, 8'h00);
    wr(IDX_MODE_SELECT, 8'h25);
    wr(IDX_RUN_CONTROL, 8'h85);
    wait_ev(1'b1, v);
    check("match a before transfer", 16'h0003, v);
    wait_ev(1'b0, v);
    check("match b clear", 16'h0000, v);
    rd(IDX_STATUS, q);
    check("buffer flags", 16'h0003, {8'h00, q});
    wait_ev(1'b1, v);
    check("match a after transfer", 16'h0006, v);
    // full wrap with the fastest pin rate: one pulse, back at zero
    wr(IDX_RUN_CONTROL, 8'h00);
    wr(IDX_MODE_SELECT, 8'h20);
    wr(IDX_RUN_CONTROL, 8'h01);
    repeat (65536) begin
      ext_clk <= 1'b1;
      @(posedge clk_i);
      ext_clk <= 1'b0;
      @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    check("overflow pulses", 16'h0001, 16'(irq_seen));
    check("overflow wrap", 16'h0000, irq_val);
    check("count after wrap", 16'h0000, counter);
    // second reset in mid-run
    wr(IDX_RUN_CONTROL, 8'h05);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_RUN_CONTROL, q);
    check("run after reset", {8'h00, RST_RUN_CONTROL}, {8'h00, q});
    rd(IDX_MODE_SELECT, q);
    check("mode after reset", {8'h00, RST_MODE_SELECT}, {8'h00, q});
    check("count after reset", 16'h0000, counter);
    wrap_up;
  end

  // the wrap alone takes about 131k cycles
  initial begin : watchdog
    repeat (200000) @(posedge clk_i);
    num_errors++;
    wrap_up;
  end
endmodule : sixteen_bit_timer_counter_core_test
